// *** rtl/cpucc_core.sv ***
// Notes on behaviour
// - Clear-register writes zero into every bit of the addressed byte.
// - Clear-register sets the zero flag; all other status flags stay.
// - Bank-access bit 0 addresses the access bank.
// - Bank-access bit 1 addresses the bank picked by the bank pointer.
// - Extended mode, access bit 0, field up to 95: indexed offset mode.
// - Clear-register: decode, read, process, write back in four quarters.
// - Watchdog kick zeroes the watchdog counter.
// - Watchdog kick sets both active-low expiry and sleep flags.
// - Watchdog kick: decode, idle, process, idle within one cycle.
// - Complement-register produces the bitwise inverse of the operand.
// - Destination bit 0 writes working register, 1 writes the source.
// - Call via working register pushes program counter plus 2 first.
// - Call loads counter from working register and the two latches.
// - Call takes two cycles; the second is a no-operation.
module cpucc_core (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Watchdog side.
  output logic wdt_clear
);

  // ----------------------------------------------------------------------
  // State, data memory and helpers.
  // ----------------------------------------------------------------------
  cpucc_pkg::cpucc_regs_s r;
  cpucc_pkg::cpucc_regs_s next;
  logic [7:0] mem [0:4095];
  logic mem_we;
  logic [11:0] mem_wa;
  logic [7:0] mem_wd;
  logic [31:0] rd_mux;
  logic busy;
  logic apb_wr;
  cpucc_pkg::cpucc_kind_e kind;

  // Outputs come straight from the state; the slave never waits.
  assign prdata = r.prdata;
  assign pslverr = r.err;
  assign pready = 1'b1;
  assign wdt_clear = r.wdt_clear;
  assign busy = r.st != cpucc_pkg::S_IDLE;
  assign kind = cpucc_pkg::cpucc_kind(r.op);
  // A refused setup blocks its access phase, so errors never half-write.
  assign apb_wr = psel && penable && pwrite && !r.err;

  // ----------------------------------------------------------------------
  // Read data selection, sampled in the setup phase.
  // ----------------------------------------------------------------------
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (paddr)
      cpucc_pkg::OFF_CTRL: rd_mux[cpucc_pkg::CTRL_EXT] = r.ext_en;
      cpucc_pkg::OFF_INSTR: rd_mux = {15'h0000, busy, r.op};
      cpucc_pkg::OFF_WORK: rd_mux[7:0] = r.work;
      cpucc_pkg::OFF_BANK: rd_mux[7:0] = r.bank;
      cpucc_pkg::OFF_STATUS: rd_mux[7:0] = r.status;
      cpucc_pkg::OFF_PC_HI_LATCH: rd_mux[7:0] = r.pc_hi_latch;
      cpucc_pkg::OFF_PC_UP_LATCH: rd_mux[7:0] = r.pc_up_latch;
      cpucc_pkg::OFF_PC: rd_mux[20:0] = r.pc;
      cpucc_pkg::OFF_STACK: rd_mux[20:0] = r.stack_top;
      cpucc_pkg::OFF_WDT: rd_mux[7:0] = r.wdt;
      cpucc_pkg::OFF_MEM_ADDR: rd_mux[11:0] = r.mem_addr;
      cpucc_pkg::OFF_MEM_DATA: rd_mux[7:0] = mem[r.mem_addr];
      cpucc_pkg::OFF_ILO: rd_mux[11:0] = r.ilo_base;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next-state logic: bus writes first, instruction effects after them,
  // so a flag that the core sets wins over a same-cycle software write.
  // ----------------------------------------------------------------------
  always_comb
  begin
    next = r;
    next.wdt_clear = 1'b0;
    mem_we = 1'b0;
    mem_wa = r.ea;
    mem_wd = r.res;
    // Free-running watchdog stand-in; it saturates rather than wraps.
    if (r.wdt != cpucc_pkg::WDT_MAX)
      next.wdt = r.wdt + 8'h01;
    if (psel && !penable)
    begin
      next.err = !cpucc_pkg::cpucc_addr_ok(paddr) ||
        (pwrite && paddr == cpucc_pkg::OFF_INSTR && busy);
      next.prdata = rd_mux;
    end
    if (apb_wr)
    begin
      case (paddr)
        cpucc_pkg::OFF_CTRL: next.ext_en = pwdata[cpucc_pkg::CTRL_EXT];
        cpucc_pkg::OFF_INSTR:
        begin
          next.op = pwdata[15:0];
          next.st = cpucc_pkg::S_Q1;
        end
        cpucc_pkg::OFF_WORK: next.work = pwdata[7:0];
        cpucc_pkg::OFF_BANK: next.bank = pwdata[7:0];
        cpucc_pkg::OFF_STATUS: next.status = pwdata[7:0];
        cpucc_pkg::OFF_PC_HI_LATCH: next.pc_hi_latch = pwdata[7:0];
        cpucc_pkg::OFF_PC_UP_LATCH: next.pc_up_latch = pwdata[7:0];
        cpucc_pkg::OFF_PC: next.pc = pwdata[20:0];
        cpucc_pkg::OFF_MEM_ADDR: next.mem_addr = pwdata[11:0];
        cpucc_pkg::OFF_MEM_DATA:
        begin
          mem_we = 1'b1;
          mem_wa = r.mem_addr;
          mem_wd = pwdata[7:0];
        end
        cpucc_pkg::OFF_ILO: next.ilo_base = pwdata[11:0];
        default: next.err = r.err;
      endcase
    end
    case (r.st)
      cpucc_pkg::S_IDLE: next.nq = 2'h0;
      // Quarter 1: decode and resolve the operand address.
      cpucc_pkg::S_Q1:
      begin
        next.ea = cpucc_pkg::cpucc_ea(r.op[7:0], r.op[cpucc_pkg::OP_ABIT],
          r.ext_en, r.bank, r.ilo_base);
        next.st = cpucc_pkg::S_Q2;
      end
      // Quarter 2: read the file register or the working register.
      cpucc_pkg::S_Q2:
      begin
        // A kick reads nothing here; its watchdog work waits for quarter 3.
        if (kind == cpucc_pkg::K_CALL)
          next.opnd = r.work;
        else if (kind == cpucc_pkg::K_CLEAR || kind == cpucc_pkg::K_COMPL)
          next.opnd = mem[r.ea];
        next.st = cpucc_pkg::S_Q3;
      end
      // Quarter 3: process data.
      cpucc_pkg::S_Q3:
      begin
        case (kind)
          cpucc_pkg::K_CLEAR: next.res = 8'h00;
          cpucc_pkg::K_COMPL: next.res = ~r.opnd;
          cpucc_pkg::K_KICK:
          begin
            next.wdt = 8'h00;
            next.wdt_clear = 1'b1;
            next.status[cpucc_pkg::ST_EXPIRY_N] = 1'b1;
            next.status[cpucc_pkg::ST_SLEEP_N] = 1'b1;
          end
          cpucc_pkg::K_CALL:
            next.stack_top = r.pc + cpucc_pkg::PC_STEP;
          default: next.res = r.res;
        endcase
        next.st = cpucc_pkg::S_Q4;
      end
      // Quarter 4: write back, then step or jump the program counter.
      cpucc_pkg::S_Q4:
      begin
        next.pc = r.pc + cpucc_pkg::PC_STEP;
        next.st = cpucc_pkg::S_IDLE;
        case (kind)
          cpucc_pkg::K_CLEAR:
          begin
            mem_we = 1'b1;
            mem_wa = r.ea;
            mem_wd = r.res;
            next.status[cpucc_pkg::ST_ZERO] = 1'b1;
          end
          cpucc_pkg::K_COMPL:
          begin
            if (r.op[cpucc_pkg::OP_DBIT])
            begin
              mem_we = 1'b1;
              mem_wa = r.ea;
              mem_wd = r.res;
            end
            else
              next.work = r.res;
            next.status[cpucc_pkg::ST_NEG] = r.res[7];
            next.status[cpucc_pkg::ST_ZERO] = r.res == 8'h00;
          end
          cpucc_pkg::K_CALL:
          begin
            next.pc = {r.pc_up_latch[4:0], r.pc_hi_latch, r.opnd};
            next.st = cpucc_pkg::S_NOP;
          end
          default: next.st = cpucc_pkg::S_IDLE;
        endcase
      end
      // Second cycle of the call: four idle quarters while refetching.
      cpucc_pkg::S_NOP:
      begin
        next.nq = r.nq + 2'h1;
        if (r.nq == cpucc_pkg::NOP_LAST)
          next.st = cpucc_pkg::S_IDLE;
      end
      default: next.st = cpucc_pkg::S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.st <= cpucc_pkg::S_IDLE;
      r.status <= cpucc_pkg::STATUS_RST;
    end
    else
      r <= next;
  end

  // Data memory has no reset, as a real SRAM would not.
  always_ff @(posedge pclk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  // ----------------------------------------------------------------------
  // Assertions and covers.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic st_sw;
  assign st_sw = apb_wr && paddr == cpucc_pkg::OFF_STATUS;

  clear_zero_a: assert property (
    r.st == cpucc_pkg::S_Q4 && kind == cpucc_pkg::K_CLEAR
    |-> mem_we && mem_wd == 8'h00 && mem_wa == r.ea)
    else $error("clear did not write zero");
  clear_flag_a: assert property (
    r.st == cpucc_pkg::S_Q4 && kind == cpucc_pkg::K_CLEAR && !st_sw
    |=> r.status == ($past(r.status) | 8'h04))
    else $error("clear changed the wrong status bits");
  access_addr_a: assert property (
    r.st == cpucc_pkg::S_Q2 && !r.op[cpucc_pkg::OP_ABIT] &&
    !($past(r.ext_en) && r.op[7:0] <= cpucc_pkg::ILO_LIMIT)
    |-> r.ea[7:0] == r.op[7:0] &&
    (r.ea[11:8] == (r.op[7:0] < cpucc_pkg::ACC_SPLIT ? 4'h0 : 4'hf)))
    else $error("access bank address wrong");
  bank_addr_a: assert property (
    r.st == cpucc_pkg::S_Q2 && r.op[cpucc_pkg::OP_ABIT]
    |-> r.ea == {$past(r.bank[3:0]), r.op[7:0]})
    else $error("banked address wrong");
  ilo_addr_a: assert property (
    r.st == cpucc_pkg::S_Q2 && !r.op[cpucc_pkg::OP_ABIT] &&
    $past(r.ext_en) && r.op[7:0] <= cpucc_pkg::ILO_LIMIT
    |-> r.ea == $past(r.ilo_base) + {4'h0, r.op[7:0]})
    else $error("indexed offset address wrong");
  clear_timing_a: assert property (
    r.st == cpucc_pkg::S_Q1 && kind == cpucc_pkg::K_CLEAR
    |=> r.st == cpucc_pkg::S_Q2 ##1 r.st == cpucc_pkg::S_Q3
    ##1 (r.st == cpucc_pkg::S_Q4 && mem_we) ##1 !busy)
    else $error("clear quarter sequence wrong");
  wdt_zero_a: assert property (
    r.st == cpucc_pkg::S_Q3 && kind == cpucc_pkg::K_KICK
    |=> r.wdt == 8'h00 && wdt_clear ##1 r.wdt == 8'h01)
    else $error("watchdog not cleared");
  wdt_flags_a: assert property (
    r.st == cpucc_pkg::S_Q3 && kind == cpucc_pkg::K_KICK
    |=> r.status[cpucc_pkg::ST_EXPIRY_N] &&
    r.status[cpucc_pkg::ST_SLEEP_N])
    else $error("kick did not set the flags");
  kick_quiet_a: assert property (
    r.st == cpucc_pkg::S_Q1 && kind == cpucc_pkg::K_KICK
    |=> (!mem_we || apb_wr) [*3] ##1 !busy)
    else $error("kick touched memory or overran");
  compl_result_a: assert property (
    r.st == cpucc_pkg::S_Q3 && kind == cpucc_pkg::K_COMPL
    |=> r.res == ~$past(r.opnd))
    else $error("complement result wrong");
  compl_dest_a: assert property (
    r.st == cpucc_pkg::S_Q4 && kind == cpucc_pkg::K_COMPL
    |-> (r.op[cpucc_pkg::OP_DBIT] ? (mem_we && mem_wd == r.res) : !mem_we
    || apb_wr))
    else $error("complement destination wrong");
  compl_flags_a: assert property (
    r.st == cpucc_pkg::S_Q4 && kind == cpucc_pkg::K_COMPL
    |=> r.status[cpucc_pkg::ST_NEG] == $past(r.res[7]) &&
    r.status[cpucc_pkg::ST_ZERO] == ($past(r.res) == 8'h00))
    else $error("complement flags wrong");
  call_push_a: assert property (
    r.st == cpucc_pkg::S_Q3 && kind == cpucc_pkg::K_CALL
    |=> r.stack_top == $past(r.pc) + cpucc_pkg::PC_STEP)
    else $error("call pushed wrong address");
  call_target_a: assert property (
    r.st == cpucc_pkg::S_Q4 && kind == cpucc_pkg::K_CALL
    |=> r.pc == {$past(r.pc_up_latch[4:0]), $past(r.pc_hi_latch),
    $past(r.opnd)})
    else $error("call target wrong");
  call_two_a: assert property (
    r.st == cpucc_pkg::S_Q4 && kind == cpucc_pkg::K_CALL
    |=> (r.st == cpucc_pkg::S_NOP) [*4] ##1 !busy)
    else $error("call second cycle wrong");

  clear_run_c: cover property (r.st == cpucc_pkg::S_Q4 &&
    kind == cpucc_pkg::K_CLEAR);
  compl_work_c: cover property (r.st == cpucc_pkg::S_Q4 &&
    kind == cpucc_pkg::K_COMPL && !r.op[cpucc_pkg::OP_DBIT]);
  call_run_c: cover property (r.st == cpucc_pkg::S_NOP &&
    r.nq == cpucc_pkg::NOP_LAST);
  busy_err_c: cover property (pslverr && penable);

endmodule

// *** rtl/cpucc_pkg.sv ***
package cpucc_pkg;

  // ----------------------------------------------------------------------
  // Register map, byte addresses on the APB side.
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_WORK = 8'h08;
  localparam logic [7:0] OFF_BANK = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_PC_HI_LATCH = 8'h14;
  localparam logic [7:0] OFF_PC_UP_LATCH = 8'h18;
  localparam logic [7:0] OFF_PC = 8'h1c;
  localparam logic [7:0] OFF_STACK = 8'h20;
  localparam logic [7:0] OFF_WDT = 8'h24;
  localparam logic [7:0] OFF_MEM_ADDR = 8'h28;
  localparam logic [7:0] OFF_MEM_DATA = 8'h2c;
  localparam logic [7:0] OFF_ILO = 8'h30;

  // ----------------------------------------------------------------------
  // Status bit positions and reset values.
  // ----------------------------------------------------------------------
  localparam int ST_EXPIRY_N = 6;
  localparam int ST_SLEEP_N = 5;
  localparam int ST_NEG = 4;
  localparam int ST_ZERO = 2;
  localparam logic [7:0] STATUS_RST = 8'h60;
  localparam int CTRL_EXT = 0;
  localparam int INSTR_BUSY = 16;

  // ----------------------------------------------------------------------
  // Opcodes, operand fields and addressing constants.
  // ----------------------------------------------------------------------
  localparam logic [15:0] OP_CALL_WORK = 16'h0014;
  localparam logic [15:0] OP_KICK = 16'h0004;
  localparam logic [6:0] OP_CLEAR_HI = 7'h35;
  localparam logic [5:0] OP_COMPL_HI = 6'h07;
  localparam int OP_ABIT = 8;
  localparam int OP_DBIT = 9;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [7:0] ILO_LIMIT = 8'h5f;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [7:0] WDT_MAX = 8'hff;
  localparam logic [1:0] NOP_LAST = 2'h3;

  // ----------------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_Q1 = 6'h02,
    S_Q2 = 6'h04,
    S_Q3 = 6'h08,
    S_Q4 = 6'h10,
    S_NOP = 6'h20
  } cpucc_state_e;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_CALL = 3'h1,
    K_CLEAR = 3'h2,
    K_KICK = 3'h3,
    K_COMPL = 3'h4
  } cpucc_kind_e;

  typedef struct packed {
    cpucc_state_e st;
    logic [1:0] nq;
    logic [15:0] op;
    logic [11:0] ea;
    logic [7:0] opnd;
    logic [7:0] res;
    logic [7:0] work;
    logic [7:0] bank;
    logic [7:0] status;
    logic [7:0] pc_hi_latch;
    logic [7:0] pc_up_latch;
    logic [20:0] pc;
    logic [20:0] stack_top;
    logic [7:0] wdt;
    logic ext_en;
    logic [11:0] mem_addr;
    logic [11:0] ilo_base;
    logic [31:0] prdata;
    logic err;
    logic wdt_clear;
  } cpucc_regs_s;

  // Classifies an instruction word into one of the supported kinds.
  function automatic cpucc_kind_e cpucc_kind(input logic [15:0] op);
    if (op == OP_CALL_WORK) return K_CALL;
    if (op == OP_KICK) return K_KICK;
    if (op[15:9] == OP_CLEAR_HI) return K_CLEAR;
    if (op[15:10] == OP_COMPL_HI) return K_COMPL;
    return K_NONE;
  endfunction

  // Resolves the 8-bit operand field into a 12-bit data address.
  function automatic logic [11:0] cpucc_ea(input logic [7:0] f,
    input logic a, input logic ext, input logic [7:0] bank,
    input logic [11:0] ilo);
    if (!a && ext && f <= ILO_LIMIT) return ilo + {4'h0, f};
    if (!a) return (f < ACC_SPLIT) ? {4'h0, f} : {ACC_HIGH_BANK, f};
    return {bank[3:0], f};
  endfunction

  // True for every mapped register offset.
  function automatic logic cpucc_addr_ok(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= OFF_ILO;
  endfunction

endpackage

// *** tb/cpu_clear_complement_ops_bench.sv ***
module cpu_clear_complement_ops_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------
  // Signals and bookkeeping.
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic skip;
    logic err;
    logic [31:0] data;
  } cpucc_note_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wdt_clear;
  logic [7:0] paddr, v, w, h, e;
  logic [31:0] pwdata, prdata, rd_val;
  logic pm_load;
  logic [20:0] pm_addr, exp_pc;
  logic [15:0] pm_wdata, pm_word;
  cpucc_note_s notes[$];
  cpucc_note_s cur;
  int n_errors, checked, kicks;
  logic [11:0] ea_t [3] = '{12'h010, 12'hf60, 12'h25f};
  logic [7:0] f_t [3] = '{8'h10, 8'h60, 8'h5f};
  logic ext_t [3] = '{1'b0, 1'b1, 1'b1};
  logic d_t [3] = '{1'b1, 1'b1, 1'b0};

  cpucc_core cpucc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdt_clear(wdt_clear));
  cpucc_prog_mem cpucc_prog_mem_inst (.pclk(pclk), .load(pm_load),
    .addr(pm_addr), .load_word(pm_wdata), .word(pm_word));

  // ---------------------------------------------------------------------
  // Checking and closing.
  // ---------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("Checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Every finished transfer is paired with the oldest note of the driver.
  always @(posedge pclk)
  begin
    if (wdt_clear === 1'b1)
      kicks++;
    if (presetn === 1'b1 && psel && penable && pready === 1'b1)
    begin
      cur = notes.pop_front();
      check("slave error", {31'h0, pslverr}, {31'h0, cur.err});
      if (!cur.skip)
        check("read data", prdata, cur.data);
    end
  end

  // ---------------------------------------------------------------------
  // Bus driver.
  // ---------------------------------------------------------------------
  // The request is held until pready is seen high, then released.
  task automatic xfer(input logic wr_n, input logic [7:0] a,
    input logic [31:0] d, input logic skip, input logic err,
    input logic [31:0] exp);
    notes.push_back('{skip, err, exp});
    psel <= 1'b1;
    pwrite <= wr_n;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never sees pready.
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_val = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b1, 1'b0, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0, 1'b0, 1'b0, x);
  endtask

  // Fetch the word at the expected counter, start it and poll busy.
  // Polls land three cycles apart, so the count of busy polls tells a
  // one-cycle instruction from a two-cycle one. The busy argument counts
  // the polls that find the core busy; a refused start takes the slot of
  // the first poll, since it lands in the same busy window.
  task automatic run(input logic [15:0] op, input int busy,
    input logic refuse);
    int n;
    rd(cpucc_pkg::OFF_PC, {11'h0, exp_pc});
    pm_load <= 1'b1;
    pm_addr <= exp_pc;
    pm_wdata <= op;
    @(posedge pclk);
    pm_load <= 1'b0;
    repeat (3) @(posedge pclk);
    wr(cpucc_pkg::OFF_INSTR, {16'h0, pm_word});
    if (refuse)
      xfer(1'b1, cpucc_pkg::OFF_INSTR, {16'h0, cpucc_pkg::OP_KICK},
        1'b1, 1'b1, 32'h0);
    n = 0;
    do
    begin
      xfer(1'b0, cpucc_pkg::OFF_INSTR, 32'h0, 1'b1, 1'b0, 32'h0);
      n++;
    end
    while (rd_val[cpucc_pkg::INSTR_BUSY] !== 1'b0 && n < 20);
    check("busy polls", n, busy + 1);
    exp_pc = exp_pc + 21'h2;
  endtask

  // ---------------------------------------------------------------------
  // Clock, watchdog and main sequence.
  // ---------------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // The sequence needs about 250 cycles; this is far beyond.
  initial
  begin
    #(40 * 20000);
    n_errors++;
    print_verdict();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pm_load = 1'b0;
    pm_addr = 21'h0;
    pm_wdata = 16'h0;
    exp_pc = 21'h0;
    void'($urandom(32'h1681));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(cpucc_pkg::OFF_STATUS, 32'h60);
    xfer(1'b0, 8'h34, 32'h0, 1'b0, 1'b1, 32'h0);
    // Banked clear, with a refused second start while busy.
    v = 8'($urandom()) | 8'h01;
    h = 8'($urandom());
    w = 8'($urandom());
    wr(cpucc_pkg::OFF_BANK, {28'h0, h[3:0]});
    wr(cpucc_pkg::OFF_MEM_ADDR, {20'h0, h[3:0], w});
    wr(cpucc_pkg::OFF_MEM_DATA, {24'h0, v});
    wr(cpucc_pkg::OFF_STATUS, 32'h10);
    run({cpucc_pkg::OP_CLEAR_HI, 1'b1, w}, 0, 1'b1);
    rd(cpucc_pkg::OFF_MEM_DATA, 32'h0);
    rd(cpucc_pkg::OFF_STATUS, 32'h14);
    check("refused start", kicks, 0);
    // Complement through the access bank and the indexed offset mode.
    wr(cpucc_pkg::OFF_ILO, 32'h200);
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 8'hff : 8'($urandom());
      e = d_t[i] ? ~v : v;
      wr(cpucc_pkg::OFF_CTRL, {31'h0, ext_t[i]});
      wr(cpucc_pkg::OFF_MEM_ADDR, {20'h0, ea_t[i]});
      wr(cpucc_pkg::OFF_MEM_DATA, {24'h0, v});
      wr(cpucc_pkg::OFF_STATUS, 32'h60);
      wr(cpucc_pkg::OFF_WORK, 32'h0);
      run({cpucc_pkg::OP_COMPL_HI, d_t[i], 1'b0, f_t[i]}, 1, 1'b0);
      rd(cpucc_pkg::OFF_MEM_DATA, {24'h0, e});
      e = d_t[i] ? 8'h0 : ~v;
      rd(cpucc_pkg::OFF_WORK, {24'h0, e});
      e = {3'h3, ~v[7], 1'b0, ~v == 8'h0, 2'h0};
      rd(cpucc_pkg::OFF_STATUS, {24'h0, e});
    end
    // Call through the working register, then a watchdog kick.
    w = 8'($urandom());
    h = 8'($urandom());
    wr(cpucc_pkg::OFF_WORK, {24'h0, w});
    wr(cpucc_pkg::OFF_PC_HI_LATCH, {24'h0, h});
    wr(cpucc_pkg::OFF_PC_UP_LATCH, {27'h0, v[4:0]});
    run(cpucc_pkg::OP_CALL_WORK, 3, 1'b0);
    rd(cpucc_pkg::OFF_STACK, {11'h0, exp_pc});
    exp_pc = {v[4:0], h, w};
    rd(cpucc_pkg::OFF_PC, {11'h0, exp_pc});
    wr(cpucc_pkg::OFF_STATUS, 32'h0);
    run(cpucc_pkg::OP_KICK, 1, 1'b0);
    check("kick pulses", kicks, 1);
    rd(cpucc_pkg::OFF_STATUS, 32'h60);
    xfer(1'b0, cpucc_pkg::OFF_WDT, 32'h0, 1'b1, 1'b0, 32'h0);
    check("watchdog low", {31'h0, rd_val < 32'h10}, 32'h1);
    print_verdict();
  end
endmodule

// *** tb/cpucc_prog_mem.sv ***
// ---------------------------------------------------------------------
// Program store that hands instruction words to the bench.
// ---------------------------------------------------------------------
module cpucc_prog_mem (
  // Clock.
  input wire logic pclk,
  // Loading side.
  input wire logic load,
  input wire logic [20:0] addr,
  input wire logic [15:0] load_word,
  // Fetch side.
  output logic [15:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:15];

  // A fetch answers one edge late, as a synchronous store would.
  // Slots never loaded stay unknown, so a stray fetch is seen at once.
  always @(posedge pclk)
  begin
    if (load)
      mem[addr[4:1]] <= load_word;
    word <= mem[addr[4:1]];
  end
endmodule
